// ==== rtl/pos_output_stage.sv ====
`timescale 1ns/1ns
`include "pos_defs.svh"
module pos_output_stage (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_sel_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  // Generator channels
  input wire logic [5:0] pwm_gen,
  // Port logic levels
  input wire logic [5:0] port_a_out,
  input wire logic [5:0] port_b_out,
  // Pins
  output logic [5:0] pin_a,
  output logic [5:0] pin_a_pwm,
  output logic [5:0] pin_b,
  output logic [5:0] pin_b_pwm
);
  // ****************************************************
  // Registers
  // ****************************************************
  logic [7:0] sel_a;
  logic [7:0] sel_b;
  logic [7:0] dt_en;
  logic [7:0] dt_cnt;
  logic [7:0] mask_en;
  logic [7:0] mask_data;
  logic [2:0] comp_mode;
  logic pwm_run;
  logic ta_open;
  logic [2:0] ta_timer;
  pos_pkg::pos_ta_state_t ta_state;
  logic req;
  logic wr;
  logic [7:0] next_rdata;
  logic [5:0] dt_out;
  logic [5:0] ch_final;
  logic dt_blocked;
  pos_pkg::pos_count_t dt_count;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Write lands at the edge where the master samples ack high
  assign wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i;
  assign dt_count = {dt_en[`POS_DT_BIT8], dt_cnt};

  // ****************************************************
  // Bus answer
  // ****************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `POS_RESET_BYTE;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  // Unmapped offsets read zero; writes to them, other than the key offset, only close the timed-access window
  always_comb begin
    unique case (wb_adr_i)
      `POS_OFF_SEL_A: next_rdata = sel_a;
      `POS_OFF_SEL_B: next_rdata = sel_b;
      `POS_OFF_DT_EN: next_rdata = dt_en;
      `POS_OFF_DT_CNT: next_rdata = dt_cnt;
      `POS_OFF_MASK_EN: next_rdata = mask_en;
      `POS_OFF_MASK_DATA: next_rdata = mask_data;
      `POS_OFF_CTRL: next_rdata = {4'h0, pwm_run, comp_mode};
      `POS_OFF_STATUS: next_rdata = {6'h00, dt_blocked, ta_open};
      default: next_rdata = `POS_RESET_BYTE;
    endcase
  end

  // ****************************************************
  // Timed access
  // ****************************************************
  // Key pair opens a short window; any other write closes it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ta_state <= pos_pkg::POS_TA_IDLE;
      ta_timer <= 3'h0;
    end else if (wr && wb_adr_i == `POS_OFF_TA) begin
      if (wb_dat_i == `POS_TA_KEY1) begin
        ta_state <= pos_pkg::POS_TA_KEY;
      end else if (wb_dat_i == `POS_TA_KEY2 && ta_state == pos_pkg::POS_TA_KEY) begin
        ta_state <= pos_pkg::POS_TA_OPEN;
        ta_timer <= `POS_TA_WINDOW;
      end else begin
        ta_state <= pos_pkg::POS_TA_IDLE;
      end
    end else if (wr) begin
      ta_state <= pos_pkg::POS_TA_IDLE;
    end else if (ta_state == pos_pkg::POS_TA_OPEN) begin
      if (ta_timer == 3'h0) begin
        ta_state <= pos_pkg::POS_TA_IDLE;
      end else begin
        ta_timer <= ta_timer - 3'h1;
      end
    end
  end
  assign ta_open = (ta_state == pos_pkg::POS_TA_OPEN);

  // ****************************************************
  // Register writes
  // ****************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sel_a <= `POS_RESET_BYTE;
      sel_b <= `POS_RESET_BYTE;
      dt_en <= `POS_RESET_BYTE;
      dt_cnt <= `POS_RESET_BYTE;
      mask_en <= `POS_RESET_BYTE;
      mask_data <= `POS_RESET_BYTE;
      comp_mode <= 3'h0;
      pwm_run <= 1'b0;
      dt_blocked <= 1'b0;
    end else if (wr) begin
      unique case (wb_adr_i)
        `POS_OFF_SEL_A: sel_a <= wb_dat_i & `POS_SEL_A_MASK;
        `POS_OFF_SEL_B: sel_b <= wb_dat_i & `POS_SEL_B_MASK;
        `POS_OFF_DT_EN: dt_en <= wb_dat_i & `POS_DT_EN_MASK;
        `POS_OFF_DT_CNT: begin
          if (ta_open) begin
            dt_cnt <= wb_dat_i;
          end
          dt_blocked <= !ta_open;
        end
        `POS_OFF_MASK_EN: mask_en <= wb_dat_i & `POS_CH_MASK;
        `POS_OFF_MASK_DATA: mask_data <= wb_dat_i & `POS_CH_MASK;
        `POS_OFF_CTRL: begin
          comp_mode <= wb_dat_i[2:0];
          pwm_run <= wb_dat_i[3];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************
  // Dead-time pairs
  // ****************************************************
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pair
      pos_pair_if pif ();
      assign pif.in_a = pwm_gen[2*g];
      assign pif.in_b = pwm_gen[2*g+1];
      assign pif.active = comp_mode[g] && dt_en[g];
      assign pif.count = dt_count;
      assign dt_out[2*g] = pif.out_a;
      assign dt_out[2*g+1] = pif.out_b;
      pos_deadtime i_pos_deadtime (
        .clk(clk),
        .reset_n(reset_n),
        .p(pif.pair)
      );
    end
  endgenerate

  // Mask after dead-time so forced levels always win
  assign ch_final = (dt_out & ~mask_en[5:0]) | (mask_data[5:0] & mask_en[5:0]);

  // ****************************************************
  // Pin routing
  // ****************************************************
  // Registered for clean pin edges; adds one cycle of latency
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_a <= 6'h00;
      pin_a_pwm <= 6'h00;
      pin_b <= 6'h00;
      pin_b_pwm <= 6'h00;
    end else begin
      pin_a_pwm <= sel_a[5:0];
      pin_b_pwm <= sel_b[5:0];
      for (int i = 0; i < 6; i++) begin
        pin_a[i] <= sel_a[i] ? ch_final[i] : port_a_out[i];
        pin_b[i] <= sel_b[i] ? ch_final[i] : port_b_out[i];
      end
    end
  end

  // ****************************************************
  // Checks: bus and reset
  // ****************************************************
  a_ack_one_cycle: assert property (@(posedge clk) disable iff (!reset_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_follows_req: assert property (@(posedge clk) disable iff (!reset_n)
    req |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_needs_req: assert property (@(posedge clk) disable iff (!reset_n)
    wb_ack_o |-> $past(req))
    else $error("ack without request");
  a_read_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
    (req && !wb_we_i && wb_adr_i == `POS_OFF_SEL_A) |=> (wb_dat_o == $past(sel_a)))
    else $error("select a read data wrong");
  a_read_unmapped: assert property (@(posedge clk) disable iff (!reset_n)
    (req && !wb_we_i && wb_adr_i == `POS_OFF_TA) |=> (wb_dat_o == `POS_RESET_BYTE))
    else $error("write-only offset read not zero");
  a_dat_holds: assert property (@(posedge clk) disable iff (!reset_n)
    (!req || wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data changed without a read");
  a_mask_write: assert property (@(posedge clk) disable iff (!reset_n)
    (wr && wb_adr_i == `POS_OFF_MASK_EN) |=> (mask_en == ($past(wb_dat_i) & `POS_CH_MASK)))
    else $error("mask enable write lost");
  a_sel_b_write: assert property (@(posedge clk) disable iff (!reset_n)
    (wr && wb_adr_i == `POS_OFF_SEL_B) |=> (sel_b == ($past(wb_dat_i) & `POS_SEL_B_MASK)))
    else $error("select b write wrong");
  a_reset_regs: assert property (@(posedge clk)
    !reset_n |=> ((sel_a | sel_b | dt_en | dt_cnt | mask_en | mask_data) == `POS_RESET_BYTE))
    else $error("register not zero after reset");
  a_reset_outputs: assert property (@(posedge clk)
    !reset_n |=> ((pin_a_pwm | pin_b_pwm) == 6'h00 && !wb_ack_o && wb_dat_o == `POS_RESET_BYTE))
    else $error("output not idle after reset");

  // ****************************************************
  // Checks: timed access
  // ****************************************************
  a_ta_guard: assert property (@(posedge clk) disable iff (!reset_n)
    (wr && wb_adr_i == `POS_OFF_DT_CNT && !ta_open) |=> $stable(dt_cnt))
    else $error("unprotected count write accepted");
  a_ta_accept: assert property (@(posedge clk) disable iff (!reset_n)
    (wr && wb_adr_i == `POS_OFF_DT_CNT && ta_open) |=> (dt_cnt == $past(wb_dat_i)))
    else $error("protected count write lost");
  a_ta_refused_flag: assert property (@(posedge clk) disable iff (!reset_n)
    (wr && wb_adr_i == `POS_OFF_DT_CNT) |=> (dt_blocked == !$past(ta_open)))
    else $error("refused flag wrong");
  a_ta_closes: assert property (@(posedge clk) disable iff (!reset_n)
    (wr && wb_adr_i != `POS_OFF_TA) |=> !ta_open)
    else $error("access window left open");
  a_ta_window: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(ta_open) |-> ##5 !ta_open)
    else $error("access window too long");

  // ****************************************************
  // Checks: routing and masking
  // ****************************************************
  a_mask_forces_pin: assert property (@(posedge clk) disable iff (!reset_n)
    (sel_a[0] && mask_en[0]) |=> (pin_a[0] == $past(mask_data[0])))
    else $error("masked pin a0 not at mask level");
  a_mask_level_high: assert property (@(posedge clk) disable iff (!reset_n)
    (sel_a[3] && mask_en[3] && mask_data[3]) |=> pin_a[3])
    else $error("mask high not shown on pin a3");
  a_port_function: assert property (@(posedge clk) disable iff (!reset_n)
    (!sel_a[2]) |=> (pin_a[2] == $past(port_a_out[2])))
    else $error("port level not routed to pin a2");
  a_sel_b_pass: assert property (@(posedge clk) disable iff (!reset_n)
    (sel_b[5] && !mask_en[5] && !(comp_mode[2] && dt_en[2])) |=> (pin_b[5] == $past(pwm_gen[5])))
    else $error("pin b5 not following channel 5");
  a_sel_b_unused: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> (pin_b[0] == $past(port_b_out[0]) && pin_b[4] == $past(port_b_out[4])))
    else $error("pin b0 or b4 left port function");
  a_pin_a_route: assert property (@(posedge clk) disable iff (!reset_n)
    sel_a[4] |=> (pin_a[4] == $past(ch_final[4])))
    else $error("pin a4 not showing channel 4");
  a_pin_b_route: assert property (@(posedge clk) disable iff (!reset_n)
    sel_b[1] |=> (pin_b[1] == $past(ch_final[1])))
    else $error("pin b1 not showing channel 1");
  a_pwm_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> ({2'b00, pin_a_pwm} == $past(sel_a)))
    else $error("pin a function flags wrong");
  a_pwm_flag_b: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> ({2'b00, pin_b_pwm} == $past(sel_b)))
    else $error("pin b function flags wrong");
  generate
    for (g = 0; g < 6; g++) begin : g_mask_chk
      a_mask_per_chan: assert property (@(posedge clk) disable iff (!reset_n)
        mask_en[g] |-> (ch_final[g] == mask_data[g]))
        else $error("masked channel not at mask level");
      a_mask_pass_chan: assert property (@(posedge clk) disable iff (!reset_n)
        !mask_en[g] |-> (ch_final[g] == dt_out[g]))
        else $error("unmasked channel not passed through");
    end
  endgenerate

  // ****************************************************
  // Checks: dead-time
  // ****************************************************
  a_dt_holds_low: assert property (@(posedge clk) disable iff (!reset_n)
    (comp_mode[0] && dt_en[0] && !mask_en[0] && pwm_gen[0] && !g_pair[0].i_pos_deadtime.prev_a)
    |-> (ch_final[0] == 1'b0))
    else $error("rising edge not delayed on channel 0");
  a_dt_pair_b: assert property (@(posedge clk) disable iff (!reset_n)
    (comp_mode[0] && dt_en[0] && pwm_gen[1] && !g_pair[0].i_pos_deadtime.prev_b) |-> !dt_out[1])
    else $error("rising edge not delayed on channel 1");
  a_dt_fall_pass: assert property (@(posedge clk) disable iff (!reset_n)
    (comp_mode[0] && dt_en[0] && !pwm_gen[0]) |-> !dt_out[0])
    else $error("falling edge delayed on channel 0");
  a_dt_off_pass: assert property (@(posedge clk) disable iff (!reset_n)
    (!dt_en[0]) |-> (dt_out[1:0] == pwm_gen[1:0]))
    else $error("pair 0 delayed with enable clear");
  a_dt_bypass: assert property (@(posedge clk) disable iff (!reset_n)
    (!comp_mode[1] && !mask_en[2]) |-> (ch_final[2] == pwm_gen[2]))
    else $error("dead-time applied outside complementary mode");
  a_count_width: assert property (@(posedge clk) disable iff (!reset_n)
    (pwm_gen[0] && !g_pair[0].i_pos_deadtime.prev_a)
    |=> (g_pair[0].i_pos_deadtime.cnt_a == {$past(dt_en[`POS_DT_BIT8]), $past(dt_cnt)}))
    else $error("count bit 8 wrong");
  a_dt_length: assert property (@(posedge clk) disable iff (!reset_n)
    (comp_mode[0] && dt_en[0] && dt_count == 9'h002 && $stable(dt_count) && pwm_gen[0]
     && !$past(pwm_gen[0])) |-> (!ch_final[0] || mask_en[0])[*3])
    else $error("dead-time shorter than count plus one");
endmodule : pos_output_stage

// ==== inc/pos_defs.svh ====
`ifndef POS_DEFS_SVH
`define POS_DEFS_SVH
`define POS_OFF_SEL_B 8'hc6
`define POS_OFF_SEL_A 8'hde
`define POS_OFF_DT_EN 8'hf9
`define POS_OFF_DT_CNT 8'hfa
`define POS_OFF_MASK_EN 8'hfb
`define POS_OFF_MASK_DATA 8'hfc
`define POS_OFF_CTRL 8'hf0
`define POS_OFF_TA 8'hf1
`define POS_OFF_STATUS 8'hf2
`define POS_TA_KEY1 8'haa
`define POS_TA_KEY2 8'h55
`define POS_TA_WINDOW 3'h4
`define POS_SEL_A_MASK 8'h3f
`define POS_SEL_B_MASK 8'h2e
`define POS_DT_EN_MASK 8'h17
`define POS_CH_MASK 8'h3f
`define POS_DT_BIT8 4
`define POS_RESET_BYTE 8'h00
`define POS_DT_ZERO 9'h000
`define POS_DT_ONE 9'h001
`endif

// ==== inc/pos_pkg.sv ====
package pos_pkg;
  typedef logic [5:0] pos_chan_t;
  typedef logic [8:0] pos_count_t;
  typedef enum logic [1:0] {
    POS_TA_IDLE = 2'b00,
    POS_TA_KEY = 2'b01,
    POS_TA_OPEN = 2'b11
  } pos_ta_state_t;
endpackage : pos_pkg

// ==== inc/pos_pair_if.sv ====
`timescale 1ns/1ns
interface pos_pair_if;
  logic in_a;
  logic in_b;
  logic active;
  pos_pkg::pos_count_t count;
  logic out_a;
  logic out_b;
  modport ctrl (output in_a, output in_b, output active, output count, input out_a, input out_b);
  modport pair (input in_a, input in_b, input active, input count, output out_a, output out_b);
endinterface : pos_pair_if

// ==== rtl/pos_deadtime.sv ====
`timescale 1ns/1ns
`include "pos_defs.svh"
module pos_deadtime (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Pair link
  pos_pair_if.pair p
);
  pos_pkg::pos_count_t cnt_a;
  pos_pkg::pos_count_t cnt_b;
  logic prev_a;
  logic prev_b;

  // Rising edge restarts the count; output follows after count+1 cycles
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
      cnt_a <= `POS_DT_ZERO;
      cnt_b <= `POS_DT_ZERO;
    end else begin
      prev_a <= p.in_a;
      prev_b <= p.in_b;
      if (p.in_a && !prev_a) begin
        cnt_a <= p.count;
      end else if (cnt_a != `POS_DT_ZERO) begin
        cnt_a <= cnt_a - `POS_DT_ONE;
      end
      if (p.in_b && !prev_b) begin
        cnt_b <= p.count;
      end else if (cnt_b != `POS_DT_ZERO) begin
        cnt_b <= cnt_b - `POS_DT_ONE;
      end
    end
  end

  // Held low during the delay; falling edges pass at once
  always_comb begin
    if (p.active) begin
      p.out_a = p.in_a && prev_a && (cnt_a == `POS_DT_ZERO);
      p.out_b = p.in_b && prev_b && (cnt_b == `POS_DT_ZERO);
    end else begin
      p.out_a = p.in_a;
      p.out_b = p.in_b;
    end
  end
endmodule : pos_deadtime

// ==== bench/pos_port_model.sv ====
`timescale 1ns/1ns
// ****************
// Port logic model
// ****************
module pos_port_model #(
  parameter logic [5:0] LEVEL_A = 6'h2a,
  parameter logic [5:0] LEVEL_B = 6'h2b
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Port levels
  output logic [5:0] port_a_out,
  output logic [5:0] port_b_out
);
  // Distinct levels per pin, inverted out of reset, so a wrong or stale route shows
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port_a_out <= LEVEL_A;
      port_b_out <= LEVEL_B;
    end else begin
      port_a_out <= ~LEVEL_A;
      port_b_out <= ~LEVEL_B;
    end
  end
endmodule : pos_port_model

// ==== bench/test_pwm_output_stage.sv ====
`timescale 1ns/1ns
`include "pos_defs.svh"
module test_pwm_output_stage;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_sel_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00, wb_dat_i = 8'h00, wb_dat_o, rd;
  logic [5:0] pwm_gen = 6'h00, port_a_out, port_b_out, pin_a, pin_a_pwm, pin_b, pin_b_pwm;
  int n_fail = 0;
  int checked = 0;
  pos_port_model i_pos_port_model (.clk(clk), .reset_n(reset_n), .port_a_out(port_a_out), .port_b_out(port_b_out));
  pos_output_stage i_pos_output_stage (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pwm_gen(pwm_gen), .port_a_out(port_a_out), .port_b_out(port_b_out), .pin_a(pin_a),
    .pin_a_pwm(pin_a_pwm), .pin_b(pin_b), .pin_b_pwm(pin_b_pwm));
  initial begin
    forever #20 clk = ~clk;
  end
  // ****************
  // Helpers
  // ****************
  task wrap_up;
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask : chk
  // Starts and ends just after a rising edge
  task wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 20) begin
      $display("Error wb_ack expected 1 seen 0");
      n_fail++;
      wrap_up();
    end else begin
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
    end
  endtask : wb
  task rchk(input logic [7:0] adr, input logic [7:0] exp);
    wb(1'b0, adr, 8'h00);
    chk("read", {1'b0, exp}, {1'b0, rd});
  endtask : rchk
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  // Cycles from a channel 0 rise at the input to its pin
  task measure(input logic [8:0] exp);
    int n;
    pwm_gen <= 6'h02;
    repeat (4) @(posedge clk);
    pwm_gen <= 6'h01;
    for (n = 1; n < 400; n++) begin
      @(posedge clk);
      #1;
      if (pin_a[0] === 1'b1) break;
    end
    chk("delay", exp, n[8:0]);
    @(posedge clk);
  endtask : measure
  // ****************
  // Scenarios
  // ****************
  task t_reset;
    logic [7:0] offs [7];
    offs = '{`POS_OFF_SEL_B, `POS_OFF_SEL_A, `POS_OFF_DT_EN, `POS_OFF_DT_CNT, `POS_OFF_MASK_EN, `POS_OFF_MASK_DATA, 8'ha0};
    foreach (offs[k]) rchk(offs[k], `POS_RESET_BYTE);
    settle();
    chk("pin_a", {3'h0, port_a_out}, {3'h0, pin_a});
    chk("pin_pwm", 9'h000, {3'h0, pin_a_pwm | pin_b_pwm});
    @(posedge clk);
  endtask : t_reset
  task t_route;
    pwm_gen <= 6'h15;
    wb(1'b1, `POS_OFF_SEL_A, 8'hff);
    wb(1'b1, `POS_OFF_SEL_B, 8'hff);
    settle();
    chk("pin_a_pwm", 9'h03f, {3'h0, pin_a_pwm});
    chk("pin_a", 9'h015, {3'h0, pin_a});
    chk("pin_b_pwm", 9'h02e, {3'h0, pin_b_pwm});
    chk("pin_b", {3'h0, (6'h15 & 6'h2e) | (port_b_out & 6'h11)}, {3'h0, pin_b});
    @(posedge clk);
    wb(1'b1, `POS_OFF_SEL_B, 8'h00);
  endtask : t_route
  task t_mask;
    wb(1'b1, `POS_OFF_MASK_EN, 8'h3c);
    wb(1'b1, `POS_OFF_MASK_DATA, 8'h2a);
    settle();
    chk("masked", 9'h029, {3'h0, pin_a});
    @(posedge clk);
    wb(1'b1, `POS_OFF_MASK_EN, 8'h00);
  endtask : t_mask
  task t_dead;
    wb(1'b1, `POS_OFF_CTRL, 8'h00);
    wb(1'b1, `POS_OFF_DT_CNT, 8'h07);
    rchk(`POS_OFF_DT_CNT, 8'h00);
    wb(1'b0, `POS_OFF_STATUS, 8'h00);
    chk("refused", 9'h001, {8'h00, rd[1]});
    wb(1'b1, `POS_OFF_TA, `POS_TA_KEY1);
    wb(1'b1, `POS_OFF_TA, `POS_TA_KEY2);
    wb(1'b1, `POS_OFF_DT_CNT, 8'h02);
    rchk(`POS_OFF_DT_CNT, 8'h02);
    wb(1'b1, `POS_OFF_DT_EN, 8'h11);
    measure(9'h001);
    wb(1'b1, `POS_OFF_CTRL, 8'h01);
    measure(9'h102 + 9'h002);
    wb(1'b1, `POS_OFF_DT_EN, 8'h01);
    measure(9'h002 + 9'h002);
    wb(1'b1, `POS_OFF_DT_EN, 8'h10);
    measure(9'h001);
    wb(1'b1, `POS_OFF_DT_EN, 8'h11);
    wb(1'b1, `POS_OFF_MASK_EN, 8'h01);
    wb(1'b1, `POS_OFF_MASK_DATA, 8'h01);
    pwm_gen <= 6'h02;
    settle();
    chk("mask_dt", 9'h001, {8'h00, pin_a[0]});
    @(posedge clk);
  endtask : t_dead
  // Mid-run reset must clear registers that were set
  task t_rereset;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rchk(`POS_OFF_SEL_A, `POS_RESET_BYTE);
    rchk(`POS_OFF_DT_EN, `POS_RESET_BYTE);
    rchk(`POS_OFF_MASK_DATA, `POS_RESET_BYTE);
    rchk(`POS_OFF_TA, `POS_RESET_BYTE);
  endtask : t_rereset
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_route();
    t_mask();
    t_dead();
    t_rereset();
    wrap_up();
  end
  // Whole-run guard
  initial begin
    #2000000;
    n_fail++;
    wrap_up();
  end
endmodule : test_pwm_output_stage
